// ---- trar_receiver.sv ----
// Purpose: automatic answer control and start-stop receiver with
//          stop interval regeneration and resynchronizer
// Assumes: pins arrive asynchronously; line mark is logic 1
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps

module trar_receiver
  import trar_pkg::*;
#(
  parameter int unsigned DATA_BITS = DATA_BITS_DEF,
  parameter int unsigned HALF_CYC = HALF_BIT_CYC,
  parameter int unsigned ADV_CYC = BIT_CYC,
  parameter int unsigned STOP5_CYC = STOP_5LVL_CYC,
  parameter int unsigned STOP8_CYC = STOP_8LVL_CYC
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic interlock_pin,
  input wire logic carrier_pin,
  input wire logic line_pin,
  input wire logic universal_mode,
  output logic motor_relay_driver,
  output logic rx_gated,
  output logic [DATA_BITS-1:0] char_data,
  output logic char_valid,
  output logic character_control_flop,
  output logic stop_interval_oneshot,
  output logic sync_gate_flop
);

  localparam int unsigned STAGES = DATA_BITS + 1;
  localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

  // ***************************************************************
  // parameter checks
  // ***************************************************************
  if (DATA_BITS < 1 || HALF_CYC < 1 || ADV_CYC < 1 || STOP5_CYC < 1 ||
      STOP8_CYC < 1 || HALF_CYC > CNT_MAX || ADV_CYC > CNT_MAX ||
      STOP5_CYC > CNT_MAX || STOP8_CYC > CNT_MAX)
  begin : g_bad_param
    $error("trar_receiver: parameter out of range");
  end

  // ***************************************************************
  // pin synchronizers
  // ***************************************************************
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, stable_q;
  logic [PIN_W-1:0] stable_d;
  // line idles at mark so no false start follows reset
  localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(LINE_MARK) << PIN_LINE;

  assign pins = {universal_mode, line_pin, carrier_pin, interlock_pin};

  always_comb
  begin
    stable_d = (s3_q & ~(s2_q ^ s3_q)) | (stable_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      stable_q <= PIN_IDLE;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= stable_d;
    end
  end

  logic interlock, carrier, line_in, gate_out, disconnect;
  assign interlock = stable_q[PIN_INTERLOCK];
  assign carrier = stable_q[PIN_CARRIER];
  assign line_in = carrier ? stable_q[PIN_LINE] : LINE_MARK;
  assign disconnect = !interlock && !carrier;

  // ***************************************************************
  // receive sequencing
  // ***************************************************************
  trar_phase_e phase_q, phase_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [STAGES-1:0] sh_q, sh_d, tok_q, tok_d;
  logic [DATA_BITS-1:0] data_q, data_d;
  logic valid_q, valid_d, sync_q, sync_d, edge_q, edge_d;
  logic por_q, por_d, motor_q, motor_d, gated_q, gated_d;
  logic [CNT_W-1:0] stop_len;
  logic advance;
  logic univ_sel;

  assign univ_sel = stable_q[PIN_UNIV];
  assign stop_len = univ_sel ? CNT_W'(STOP8_CYC - 1)
                             : CNT_W'(STOP5_CYC - 1);

  // gate holds mark while the one-shot runs, then until a space or sync
  assign gate_out = (phase_q == PH_STOP) ? LINE_MARK :
                    (sync_q || edge_q || line_in == LINE_SPACE) ?
                    line_in : LINE_MARK;
  assign advance = (phase_q == PH_RUN) && (cnt_q == '0);

  always_comb
  begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tok_d = tok_q;
    data_d = data_q;
    valid_d = 1'b0;
    sync_d = sync_q;
    edge_d = edge_q;
    por_d = 1'b0;
    motor_d = interlock;
    gated_d = gate_out;
    if (!sync_q && line_in == LINE_SPACE)
      edge_d = 1'b1;
    if (por_q)
    begin
      // one shift, control flop clear, one-shot fired
      sh_d = {sh_q[STAGES-2:0], LINE_MARK};
      tok_d = '0;
      phase_d = PH_STOP;
      cnt_d = stop_len;
      sync_d = 1'b0;
      edge_d = 1'b0;
    end
    else
    begin
      case (phase_q)
        PH_IDLE:
        begin
          if (gate_out == LINE_SPACE && !disconnect)
          begin
            phase_d = PH_DELAY;
            cnt_d = CNT_W'(HALF_CYC - 1);
          end
        end
        PH_DELAY:
        begin
          if (cnt_q == '0)
          begin
            phase_d = PH_RUN;
            cnt_d = CNT_W'(ADV_CYC - 1);
            sh_d = {sh_q[STAGES-2:0], gate_out};
            tok_d = {{(STAGES-1){1'b0}}, 1'b1};
          end
          else
            cnt_d = cnt_q - 1'b1;
        end
        PH_RUN:
        begin
          if (!advance)
            cnt_d = cnt_q - 1'b1;
          else if (tok_q[STAGES-1])
          begin
            // primed: this advance clears the control flop
            phase_d = PH_STOP;
            cnt_d = stop_len;
            tok_d = '0;
            for (int i = 0; i < DATA_BITS; i++)
              data_d[i] = sh_q[STAGES-2-i];
            valid_d = 1'b1;
            sync_d = 1'b0;
            edge_d = 1'b0;
          end
          else
          begin
            cnt_d = CNT_W'(ADV_CYC - 1);
            sh_d = {sh_q[STAGES-2:0], gate_out};
            tok_d = {tok_q[STAGES-2:0], 1'b0};
          end
        end
        PH_STOP:
        begin
          if (cnt_q == '0)
          begin
            phase_d = PH_IDLE;
            sync_d = (line_in == LINE_MARK);
          end
          else
            cnt_d = cnt_q - 1'b1;
        end
        default:
          phase_d = PH_IDLE;
      endcase
      if (disconnect && phase_q != PH_STOP)
      begin
        phase_d = PH_IDLE;
        tok_d = '0;
        valid_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      phase_q <= PH_IDLE;
      cnt_q <= '0;
      sh_q <= '1;
      tok_q <= '0;
      data_q <= '0;
      valid_q <= 1'b0;
      sync_q <= 1'b0;
      edge_q <= 1'b0;
      por_q <= 1'b1;
      motor_q <= 1'b0;
      gated_q <= LINE_MARK;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tok_q <= tok_d;
      data_q <= data_d;
      valid_q <= valid_d;
      sync_q <= sync_d;
      edge_q <= edge_d;
      por_q <= por_d;
      motor_q <= motor_d;
      gated_q <= gated_d;
    end
  end

  assign motor_relay_driver = motor_q;
  assign rx_gated = gated_q;
  assign char_data = data_q;
  assign char_valid = valid_q;
  assign character_control_flop = (phase_q == PH_RUN);
  assign stop_interval_oneshot = (phase_q == PH_STOP);
  assign sync_gate_flop = sync_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [CNT_W-1:0] chk_len_q, chk_exp_q;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chk_len_q <= '0;
      chk_exp_q <= '0;
    end
    else if (phase_q != PH_STOP && phase_d == PH_STOP)
    begin
      chk_len_q <= '0;
      chk_exp_q <= stop_len;
    end
    else if (phase_q == PH_STOP)
      chk_len_q <= chk_len_q + 1'b1;
  end

  chk_motor_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(interlock) |=> motor_relay_driver)
    else $error("motor output missed interlock");
  chk_block_mark: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !carrier |=> rx_gated == LINE_MARK)
    else $error("signal not blocked without carrier");
  chk_unblock_space: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    carrier && !stop_interval_oneshot && stable_q[PIN_LINE] == LINE_SPACE
    |=> rx_gated == LINE_SPACE)
    else $error("space not passed with carrier");
  chk_disc_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    disconnect && !stop_interval_oneshot && !por_q
    |=> !character_control_flop && !motor_relay_driver)
    else $error("disconnect did not stop receiver");
  chk_stop_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(stop_interval_oneshot) |-> $past(chk_len_q) == chk_exp_q)
    else $error("stop interval wrong length");
  chk_delay_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase_q == PH_DELAY && cnt_q == '0 && !disconnect && !por_q
    |=> character_control_flop ##1 character_control_flop)
    else $error("control flop not set after delay");
  chk_prime_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    advance && tok_q[STAGES-1] && !por_q
    |=> !character_control_flop && stop_interval_oneshot
        && char_valid)
    else $error("primed advance did not end character");
  chk_sync_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(stop_interval_oneshot) |-> !sync_gate_flop)
    else $error("sync flop not cleared at one-shot start");
  chk_sync_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(stop_interval_oneshot)
    |-> sync_gate_flop == ($past(line_in) == LINE_MARK))
    else $error("sync flop wrong at one-shot end");
  chk_por_shift: assert property (@(posedge clk_sys) disable iff (sys_rst)
    por_q |=> stop_interval_oneshot && !sync_gate_flop)
    else $error("power-on sequence missing");

endmodule

// ---- trar_pkg.sv ----
// Purpose: shared constants and types for the tape receiver answer and
//          resynchronizer block
// Assumes: 20 MHz system clock
// Notes:   times are kept in ns; cycle counts derive from them
package trar_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam longint CLK_HZ = 20_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint HALF_BIT_NS = 475_000;
  localparam longint STOP_5LVL_NS = 2_900_000;
  localparam longint STOP_8LVL_NS = 950_000;

  // least times round up to whole cycles
  localparam int unsigned HALF_BIT_CYC =
    int'((HALF_BIT_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned BIT_CYC = 2 * HALF_BIT_CYC;
  localparam int unsigned STOP_5LVL_CYC =
    int'((STOP_5LVL_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned STOP_8LVL_CYC =
    int'((STOP_8LVL_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);

  // ***************************************************************
  // widths, levels and pin positions
  // ***************************************************************
  localparam int unsigned CNT_W = 17;
  localparam int unsigned DATA_BITS_DEF = 5;
  localparam int unsigned PIN_W = 4;
  localparam int unsigned PIN_INTERLOCK = 0;
  localparam int unsigned PIN_CARRIER = 1;
  localparam int unsigned PIN_LINE = 2;
  localparam int unsigned PIN_UNIV = 3;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;

  // ***************************************************************
  // receive sequencing
  // ***************************************************************
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_DELAY,
    PH_RUN,
    PH_STOP
  } trar_phase_e;

endpackage

// ---- trar_dataset_model.sv ----
// Purpose: behavioural modem data set driving interlock, carrier, line
// Assumes: one bit lasts BIT_CYC_P clock cycles; mark is logic 1
// Notes:   line changes every cycle while carrier is off
`timescale 1ns/1ps

module trar_dataset_model
  import trar_pkg::*;
#(
  parameter int unsigned BIT_CYC_P = 8
)
(
  input wire logic clk_sys,
  output logic interlock_pin,
  output logic carrier_pin,
  output logic line_pin
);
  initial
  begin
    interlock_pin = 1'b0;
    carrier_pin = 1'b0;
    line_pin = LINE_MARK;
  end

  // no carrier: the line holds no data
  always @(posedge clk_sys)
    if (!carrier_pin)
      line_pin <= ~line_pin;

  task automatic set_link(input logic il, input logic cd);
    @(posedge clk_sys);
    interlock_pin <= il;
    carrier_pin <= cd;
    if (cd)
    begin
      @(posedge clk_sys);
      line_pin <= LINE_MARK;
    end
  endtask

  task automatic set_line(input logic lvl);
    @(posedge clk_sys);
    line_pin <= lvl;
  endtask

  // start, five data bits first bit first, then tail level
  task automatic send_char(input logic [4:0] data, input logic tail);
    logic [6:0] frame;
    frame = {tail, data, LINE_SPACE};
    for (int i = 0; i < 7; i++)
      repeat (BIT_CYC_P)
      begin
        @(posedge clk_sys);
        line_pin <= frame[i];
      end
  endtask
endmodule

// ---- trar_receiver_tb_top.sv ----
// Purpose: self-checking bench for the receiver block
// Assumes: shortened counts for simulation
// Notes:   data set is modelled in trar_dataset_model
`timescale 1ns/1ps

module trar_receiver_tb_top
  import trar_pkg::*;
;
  localparam int unsigned HC = 4;
  localparam int unsigned AC = 8;
  localparam int unsigned S5 = 20;
  localparam int unsigned S8 = 10;
  localparam int IX_VALID = 0;
  localparam int IX_CTRL = 1;
  localparam int IX_MOTOR = 2;
  localparam int IX_STOP = 3;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic universal_mode = 1'b0;
  logic interlock_pin;
  logic carrier_pin;
  logic line_pin;
  logic motor_relay_driver;
  logic rx_gated;
  logic [DATA_BITS_DEF-1:0] char_data;
  logic char_valid;
  logic character_control_flop;
  logic stop_interval_oneshot;
  logic sync_gate_flop;
  logic [3:0] watch;
  int mismatches = 0;
  int num_checks = 0;

  assign watch = {stop_interval_oneshot, motor_relay_driver,
    character_control_flop, char_valid};

  always #25 clk_sys = ~clk_sys;

  trar_dataset_model #(.BIT_CYC_P(AC)) partner_u (
    .clk_sys(clk_sys),
    .interlock_pin(interlock_pin),
    .carrier_pin(carrier_pin),
    .line_pin(line_pin)
  );

  trar_receiver #(.DATA_BITS(DATA_BITS_DEF), .HALF_CYC(HC), .ADV_CYC(AC),
    .STOP5_CYC(S5), .STOP8_CYC(S8)) dut_u (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .interlock_pin(interlock_pin),
    .carrier_pin(carrier_pin),
    .line_pin(line_pin),
    .universal_mode(universal_mode),
    .motor_relay_driver(motor_relay_driver),
    .rx_gated(rx_gated),
    .char_data(char_data),
    .char_valid(char_valid),
    .character_control_flop(character_control_flop),
    .stop_interval_oneshot(stop_interval_oneshot),
    .sync_gate_flop(sync_gate_flop)
  );

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_lvl(input int ix, input logic lvl, input int lim,
    output int n);
    for (n = 0; n < lim; n++)
    begin
      @(negedge clk_sys);
      if (watch[ix] === lvl)
        return;
    end
  endtask

  // counts stop interval cycles; registered gate lags one cycle
  task automatic stop_len(input int unsigned exp_len);
    int unsigned n;
    n = 0;
    while (stop_interval_oneshot === 1'b1 && n < 200)
    begin
      if (n > 0)
        check(rx_gated === LINE_MARK, "gate open in stop");
      n++;
      @(negedge clk_sys);
    end
    check(rx_gated === LINE_MARK, "gate open at stop end");
    check(n == exp_len, "stop length");
  endtask

  task automatic t_power_on();
    int n;
    @(negedge clk_sys);
    check(motor_relay_driver === 1'b0, "motor in reset");
    check(rx_gated === LINE_MARK, "gate in reset");
    wait_lvl(IX_STOP, 1'b1, 6, n);
    check(n < 6, "no power-on stop");
    check(character_control_flop === 1'b0, "control set");
    check(sync_gate_flop === 1'b0, "sync set");
    stop_len(S5);
  endtask

  task automatic t_answer();
    int n;
    partner_u.set_link(1'b1, 1'b0);
    wait_lvl(IX_MOTOR, 1'b1, 10, n);
    check(n < 10, "motor off");
    repeat (24)
    begin
      @(negedge clk_sys);
      check(rx_gated === LINE_MARK, "no carrier gate");
      check(char_valid === 1'b0, "char without carrier");
    end
  endtask

  task automatic run_char(input logic [4:0] d, input logic tail,
    input int unsigned exp_len);
    int n;
    fork
      partner_u.send_char(d, tail);
      begin
        wait_lvl(IX_CTRL, 1'b1, HC + 12, n);
        check(n >= HC && n <= HC + 8, "start delay");
        wait_lvl(IX_VALID, 1'b1, 8 * AC, n);
        check(n < 8 * AC, "no char valid");
        check(char_data === d, "char data");
        check(character_control_flop === 1'b0, "control held");
        check(stop_interval_oneshot === 1'b1, "no stop");
        check(sync_gate_flop === 1'b0, "sync not cleared");
        stop_len(exp_len);
        check(sync_gate_flop === tail, "sync at stop end");
      end
    join
  endtask

  task automatic t_chars();
    partner_u.set_link(1'b1, 1'b1);
    repeat (10) @(negedge clk_sys);
    run_char(5'h13, LINE_MARK, S5);
    @(posedge clk_sys);
    universal_mode <= 1'b1;
    repeat (10) @(negedge clk_sys);
    run_char(5'h0a, LINE_SPACE, S8);
    partner_u.set_line(LINE_MARK);
    repeat (120) @(negedge clk_sys);
  endtask

  task automatic t_disconnect();
    int n;
    partner_u.set_link(1'b0, 1'b0);
    wait_lvl(IX_MOTOR, 1'b0, 10, n);
    check(n < 10, "motor still on");
    repeat (20)
    begin
      @(negedge clk_sys);
      check(rx_gated === LINE_MARK, "gate open idle");
    end
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_power_on();
    t_answer();
    t_chars();
    t_disconnect();
    complete_run();
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    $display("BAD %0t watchdog", $time);
    complete_run();
  end
endmodule
